// ### core/fcs_pkg.sv
package fcs_pkg;
    // ------------------------------------------------------------
    // command sequence codes
    // ------------------------------------------------------------
    localparam logic [15:0] ADR_UNLOCK1 = 16'haaaa;
    localparam logic [15:0] ADR_UNLOCK2 = 16'h5554;
    localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
    localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_SECT = 8'h30;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // status byte bit positions
    // ------------------------------------------------------------
    localparam int POS_POLL = 7;
    localparam int POS_TOGGLE = 6;
    localparam int POS_TLIMIT = 5;
    localparam int POS_WINDOW = 3;
    localparam int POS_TOGGLE2 = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int WAIT_TIME_NS = 50000;
    localparam int SUSP_TIME_NS = 15000;
    localparam int WAIT_CYC = (WAIT_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SUSP_CYC = SUSP_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_READ, ST_PROG, ST_PFAIL, ST_EWAIT, ST_ERASE, ST_SUSP
    } fcs_state_t;

    typedef enum logic [2:0] {
        SQ_IDLE, SQ_U1, SQ_U2, SQ_PADDR, SQ_E3, SQ_E4, SQ_E5
    } fcs_seq_t;
endpackage

// ### core/fcs_timer.sv
`timescale 1ns/1ns
module fcs_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] loadVal,
    input wire logic run,
    output logic expired
);
    logic [W-1:0] cnt_ff;

    // ------------------------------------------------------------
    // down counter, reload wins over counting
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= loadVal;
        end else if (run && cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'h1;
        end
    end

    // expired while idle at zero
    assign expired = (cnt_ff == '0);
endmodule

// ### core/fcs_array.sv
`timescale 1ns/1ns
module fcs_array #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic andEn,
    input wire logic [7:0] andData,
    input wire logic setEn,
    output logic [7:0] rdData
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // ------------------------------------------------------------
    // cells clear on program and on the first erase pass, only set on the second erase pass
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (andEn) begin
            mem[addr] <= mem[addr] & andData;
        end else if (setEn) begin
            mem[addr] <= fcs_pkg::ERASED_BYTE;
        end
    end

    // asynchronous read port
    assign rdData = mem[addr];
endmodule

// ### core/fcs_sequencer.sv
`timescale 1ns/1ns
module fcs_sequencer #(
    parameter int ADDR_W = 16,
    parameter int SECT_W = 4,
    parameter int unsigned WAIT_CYC = fcs_pkg::WAIT_CYC,
    parameter int unsigned PULSE_CYC = 8,
    parameter int unsigned PULSE_LIMIT = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic busWe,
    input wire logic busRe,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic writeAllow,
    output logic [7:0] busRdata,
    output logic opBusy,
    output logic eraseSuspended
);
    localparam int CNT_W = 16;
    localparam int NSECT = 1 << SECT_W;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SECT_W-1:0] sectOf(
        input logic [ADDR_W-1:0] a);
        sectOf = a[ADDR_W-1 -: SECT_W];
    endfunction

    function automatic logic isEven(input logic [ADDR_W-1:0] a);
        isEven = ~a[0];
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstMeta_ff, rstnSync_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'h0;
            rstnSync_ff <= 1'h0;
        end else begin
            rstMeta_ff <= 1'h1;
            rstnSync_ff <= rstMeta_ff;
        end
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    fcs_pkg::fcs_state_t state_ff;
    fcs_pkg::fcs_seq_t seq_ff, nxt_seq;
    logic [ADDR_W-1:0] progAddr_ff, eraseAddr_ff, arrAddr;
    logic [7:0] progData_ff, arrRd, status, andData;
    logic [NSECT-1:0] sectSel_ff;
    logic [CNT_W-1:0] pulseCnt_ff, tLoadVal;
    logic erasePhase_ff, tLimit_ff, tog_ff, tog2_ff;
    logic [7:0] busRdata_ff;
    logic opBusy_ff, eraseSusp_ff;
    logic wr, atU1, atU2, cmdReset, cmdSusp, cmdResume;
    logic progStart, chipStart, sectStart, sectAdd;
    logic tLoad, tExp, tRun, busyState, inSel, eraseSel, eraseLast;
    logic andEn, setEn, progOk, suspNow;

    // ------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADR_EXT1 = ADDR_W'(fcs_pkg::ADR_UNLOCK1);
    localparam logic [ADDR_W-1:0] ADR_EXT2 = ADDR_W'(fcs_pkg::ADR_UNLOCK2);
    assign wr = busWe && writeAllow;
    assign atU1 = (busAddr == ADR_EXT1);
    assign atU2 = (busAddr == ADR_EXT2);
    assign cmdReset = wr && busWdata == fcs_pkg::CMD_RESET
        && (seq_ff == fcs_pkg::SQ_IDLE
            || (seq_ff == fcs_pkg::SQ_U2 && atU1));
    assign cmdSusp = wr && busWdata == fcs_pkg::CMD_SUSPEND;
    assign suspNow = cmdSusp && sectSel_ff != '1;
    assign cmdResume = wr && busWdata == fcs_pkg::CMD_RESUME;
    assign progStart = state_ff == fcs_pkg::ST_READ && wr
        && seq_ff == fcs_pkg::SQ_PADDR && isEven(busAddr);
    assign chipStart = state_ff == fcs_pkg::ST_READ && wr
        && seq_ff == fcs_pkg::SQ_E5 && atU1
        && busWdata == fcs_pkg::CMD_CHIP;
    assign sectStart = state_ff == fcs_pkg::ST_READ && wr
        && seq_ff == fcs_pkg::SQ_E5 && isEven(busAddr)
        && busWdata == fcs_pkg::CMD_SECT;
    assign sectAdd = state_ff == fcs_pkg::ST_EWAIT && wr
        && isEven(busAddr) && busWdata == fcs_pkg::CMD_SECT;

    // ------------------------------------------------------------
    // sequence decoder, only listens in read/reset state
    // ------------------------------------------------------------
    // preamble steps
    always_comb begin
        nxt_seq = fcs_pkg::SQ_IDLE;
        case (seq_ff)
            fcs_pkg::SQ_IDLE: begin
                if (atU1 && busWdata == fcs_pkg::DAT_UNLOCK1) begin
                    nxt_seq = fcs_pkg::SQ_U1;
                end
            end
            fcs_pkg::SQ_U1: begin
                if (atU2 && busWdata == fcs_pkg::DAT_UNLOCK2) begin
                    nxt_seq = fcs_pkg::SQ_U2;
                end
            end
            fcs_pkg::SQ_U2: begin
                if (atU1 && busWdata == fcs_pkg::CMD_PROG) begin
                    nxt_seq = fcs_pkg::SQ_PADDR;
                end else if (atU1 && busWdata == fcs_pkg::CMD_ERASE) begin
                    nxt_seq = fcs_pkg::SQ_E3;
                end
            end
            fcs_pkg::SQ_E3: begin
                if (atU1 && busWdata == fcs_pkg::DAT_UNLOCK1) begin
                    nxt_seq = fcs_pkg::SQ_E4;
                end
            end
            fcs_pkg::SQ_E4: begin
                if (atU2 && busWdata == fcs_pkg::DAT_UNLOCK2) begin
                    nxt_seq = fcs_pkg::SQ_E5;
                end
            end
            default: nxt_seq = fcs_pkg::SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstnSync_ff) begin
        if (!rstnSync_ff) begin
            seq_ff <= fcs_pkg::SQ_IDLE;
        end else if (state_ff != fcs_pkg::ST_READ) begin
            seq_ff <= fcs_pkg::SQ_IDLE;
        end else if (wr) begin
            seq_ff <= nxt_seq;
        end
    end

    // ------------------------------------------------------------
    // shared timer: program pulse and erase wait window
    // ------------------------------------------------------------
    assign progOk = (arrRd & progData_ff) == progData_ff;
    assign tRun = state_ff == fcs_pkg::ST_PROG
        || state_ff == fcs_pkg::ST_EWAIT;
    assign tLoad = progStart || sectStart || sectAdd
        || (state_ff == fcs_pkg::ST_PROG && tExp && !progOk);
    assign tLoadVal = (sectStart || sectAdd) ? CNT_W'(WAIT_CYC - 1)
        : CNT_W'(PULSE_CYC - 1);

    fcs_timer #(.W(CNT_W)) u_timer (
        .clk(clk),
        .rstn(rstnSync_ff),
        .load(tLoad),
        .loadVal(tLoadVal),
        .run(tRun),
        .expired(tExp)
    );

    // ------------------------------------------------------------
    // array access
    // ------------------------------------------------------------
    assign eraseSel = sectSel_ff[sectOf(eraseAddr_ff)];
    assign eraseLast = erasePhase_ff && (&eraseAddr_ff);
    assign inSel = sectSel_ff[sectOf(busAddr)];
    assign andEn = (state_ff == fcs_pkg::ST_PROG && tExp)
        || (state_ff == fcs_pkg::ST_ERASE && !erasePhase_ff
            && eraseSel && !suspNow);
    assign andData = (state_ff == fcs_pkg::ST_PROG) ? progData_ff
        : fcs_pkg::ZERO_BYTE;
    assign setEn = state_ff == fcs_pkg::ST_ERASE && erasePhase_ff
        && eraseSel && !suspNow;
    assign arrAddr = (state_ff == fcs_pkg::ST_PROG) ? progAddr_ff
        : (state_ff == fcs_pkg::ST_ERASE) ? eraseAddr_ff : busAddr;

    fcs_array #(.ADDR_W(ADDR_W)) u_array (
        .clk(clk),
        .addr(arrAddr),
        .andEn(andEn),
        .andData(andData),
        .setEn(setEn),
        .rdData(arrRd)
    );

    // ------------------------------------------------------------
    // main operation state
    // ------------------------------------------------------------
    // power-up in read/reset
    always_ff @(posedge clk or negedge rstnSync_ff) begin
        if (!rstnSync_ff) begin
            state_ff <= fcs_pkg::ST_READ;
            progAddr_ff <= '0;
            progData_ff <= fcs_pkg::ZERO_BYTE;
            pulseCnt_ff <= '0;
            tLimit_ff <= 1'h0;
            sectSel_ff <= '0;
            eraseAddr_ff <= '0;
            erasePhase_ff <= 1'h0;
        end else begin
            case (state_ff)
                fcs_pkg::ST_READ: begin
                    if (progStart) begin
                        state_ff <= fcs_pkg::ST_PROG;
                        progAddr_ff <= busAddr;
                        progData_ff <= busWdata;
                        pulseCnt_ff <= '0;
                    end else if (chipStart) begin
                        state_ff <= fcs_pkg::ST_ERASE;
                        sectSel_ff <= '1;
                        eraseAddr_ff <= '0;
                        erasePhase_ff <= 1'h0;
                    end else if (sectStart) begin
                        state_ff <= fcs_pkg::ST_EWAIT;
                        sectSel_ff <= NSECT'(1) << sectOf(busAddr);
                        eraseAddr_ff <= '0;
                        erasePhase_ff <= 1'h0;
                    end
                end
                fcs_pkg::ST_PROG: begin
                    if (tExp && progOk) begin
                        state_ff <= fcs_pkg::ST_READ;
                    end else if (tExp && pulseCnt_ff
                            == CNT_W'(PULSE_LIMIT - 1)) begin
                        state_ff <= fcs_pkg::ST_PFAIL;
                        tLimit_ff <= 1'h1;
                    end else if (tExp) begin
                        pulseCnt_ff <= pulseCnt_ff + 1'h1;
                    end
                end
                fcs_pkg::ST_PFAIL: begin
                    if (cmdReset) begin
                        state_ff <= fcs_pkg::ST_READ;
                        tLimit_ff <= 1'h0;
                    end
                end
                fcs_pkg::ST_EWAIT: begin
                    if (cmdSusp) begin
                        state_ff <= fcs_pkg::ST_SUSP;
                        sectSel_ff <= '0;
                    end else if (sectAdd) begin
                        sectSel_ff[sectOf(busAddr)] <= 1'h1;
                    end else if (tExp) begin
                        state_ff <= fcs_pkg::ST_ERASE;
                    end
                end
                fcs_pkg::ST_ERASE: begin
                    if (cmdSusp && sectSel_ff != '1) begin
                        state_ff <= fcs_pkg::ST_SUSP;
                    end else if (eraseLast) begin
                        state_ff <= fcs_pkg::ST_READ;
                        sectSel_ff <= '0;
                    end else begin
                        eraseAddr_ff <= eraseAddr_ff + 1'h1;
                        if (&eraseAddr_ff) begin
                            erasePhase_ff <= 1'h1;
                        end
                    end
                end
                fcs_pkg::ST_SUSP: begin
                    if (cmdResume) begin
                        state_ff <= fcs_pkg::ST_ERASE;
                    end
                end
                default: state_ff <= fcs_pkg::ST_READ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // toggle flags
    // ------------------------------------------------------------
    assign busyState = state_ff == fcs_pkg::ST_PROG
        || state_ff == fcs_pkg::ST_PFAIL
        || state_ff == fcs_pkg::ST_EWAIT
        || state_ff == fcs_pkg::ST_ERASE;

    always_ff @(posedge clk or negedge rstnSync_ff) begin
        if (!rstnSync_ff) begin
            tog_ff <= 1'h0;
            tog2_ff <= 1'h0;
        end else if (busRe) begin
            if (busyState) begin
                tog_ff <= ~tog_ff;
            end
            if (inSel && state_ff != fcs_pkg::ST_READ) begin
                tog2_ff <= ~tog2_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // status byte
    // ------------------------------------------------------------
    always_comb begin
        status = fcs_pkg::ZERO_BYTE;
        case (state_ff)
            fcs_pkg::ST_PROG, fcs_pkg::ST_PFAIL: begin
                status[fcs_pkg::POS_POLL] = ~progData_ff[fcs_pkg::POS_POLL];
                status[fcs_pkg::POS_TOGGLE] = tog_ff;
                status[fcs_pkg::POS_TLIMIT] = tLimit_ff;
                status[fcs_pkg::POS_TOGGLE2] = 1'h1;
            end
            fcs_pkg::ST_EWAIT, fcs_pkg::ST_ERASE: begin
                status[fcs_pkg::POS_TOGGLE] = tog_ff;
                status[fcs_pkg::POS_WINDOW] = state_ff == fcs_pkg::ST_ERASE;
                status[fcs_pkg::POS_TOGGLE2] = inSel ? tog2_ff : 1'h1;
            end
            default: begin
                status[fcs_pkg::POS_POLL] = 1'h1;
                status[fcs_pkg::POS_TOGGLE] = 1'h1;
                status[fcs_pkg::POS_WINDOW] = 1'h1;
                status[fcs_pkg::POS_TOGGLE2] = tog2_ff;
            end
        endcase
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // suspended reads outside erase sectors see data
    always_ff @(posedge clk or negedge rstnSync_ff) begin
        if (!rstnSync_ff) begin
            busRdata_ff <= fcs_pkg::ZERO_BYTE;
            opBusy_ff <= 1'h0;
            eraseSusp_ff <= 1'h0;
        end else begin
            if (busRe) begin
                if (state_ff == fcs_pkg::ST_READ
                        || (state_ff == fcs_pkg::ST_SUSP && !inSel)) begin
                    busRdata_ff <= arrRd;
                end else begin
                    busRdata_ff <= status;
                end
            end
            opBusy_ff <= busyState;
            eraseSusp_ff <= state_ff == fcs_pkg::ST_SUSP;
        end
    end

    assign busRdata = busRdata_ff;
    assign opBusy = opBusy_ff;
    assign eraseSuspended = eraseSusp_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstnSync_ff);

    sequence s_progRead;
        state_ff == fcs_pkg::ST_PROG && busRe;
    endsequence
    sequence s_progDone;
        state_ff == fcs_pkg::ST_PROG && tExp && progOk;
    endsequence

    AST_PROG_START: assert property (progStart |=>
        state_ff == fcs_pkg::ST_PROG && progAddr_ff == $past(busAddr))
        else $error("program did not start after fourth cycle");
    AST_PROG_DONE: assert property (s_progDone |=>
        state_ff == fcs_pkg::ST_READ ##1 !opBusy)
        else $error("program did not return to read state");
    AST_PROG_DEAF: assert property (
        state_ff == fcs_pkg::ST_PROG && busWe |=> seq_ff == fcs_pkg::SQ_IDLE)
        else $error("command decoded during program");
    AST_POLL_BIT: assert property (s_progRead |=>
        busRdata[fcs_pkg::POS_POLL] == ~progData_ff[fcs_pkg::POS_POLL])
        else $error("poll flag not complemented");
    AST_TOGGLE: assert property (
        busRe && busyState ##1 busRe && busyState |=>
        busRdata[fcs_pkg::POS_TOGGLE] != $past(busRdata[fcs_pkg::POS_TOGGLE]))
        else $error("toggle flag did not flip");
    AST_TLIMIT: assert property (
        state_ff == fcs_pkg::ST_PFAIL && busRe |=>
        busRdata[fcs_pkg::POS_TLIMIT])
        else $error("time limit flag not set");
    AST_WINDOW: assert property (
        state_ff == fcs_pkg::ST_EWAIT && busRe && !cmdSusp |=>
        !busRdata[fcs_pkg::POS_WINDOW])
        else $error("window flag high in wait window");
    AST_SUSP_WIN: assert property (
        state_ff == fcs_pkg::ST_EWAIT && cmdSusp |=>
        state_ff == fcs_pkg::ST_SUSP && sectSel_ff == '0)
        else $error("suspend in window not immediate");
    AST_SUSP_RUN: assert property (
        state_ff == fcs_pkg::ST_ERASE && cmdSusp && sectSel_ff != '1
        |=> state_ff == fcs_pkg::ST_SUSP ##1 eraseSuspended)
        else $error("erase not suspended in time");
    AST_ABANDON: assert property (
        state_ff == fcs_pkg::ST_READ && wr && seq_ff == fcs_pkg::SQ_U1
        && !atU2 |=> seq_ff == fcs_pkg::SQ_IDLE)
        else $error("partial sequence kept after mismatch");
endmodule

// ### tb/fcs_cpu_model.sv
`timescale 1ns/1ns
module fcs_cpu_model (
    input wire logic clk,
    input wire logic [7:0] busRdata,
    output logic busWe,
    output logic busRe,
    output logic [15:0] busAddr,
    output logic [7:0] busWdata,
    output logic writeAllow
);
    logic [7:0] rdVal;
    initial begin
        writeAllow = 1'b1;
        busWe = 1'b0;
        busRe = 1'b0;
        busAddr = 16'h0000;
        busWdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        busAddr = a;
        busWdata = d;
        busWe = 1'b1;
        @(negedge clk);
        busWe = 1'b0;
        busWdata = ~d; // stale data is not kept
    endtask
    // write-allow bit of the control register
    task automatic allow(input logic v);
        @(negedge clk);
        writeAllow = v;
    endtask
    // two reads on consecutive cycles, answer of the second kept
    task automatic rd2(input logic [15:0] a);
        @(negedge clk);
        busAddr = a;
        busRe = 1'b1;
        @(negedge clk);
        @(negedge clk);
        busRe = 1'b0;
        @(negedge clk);
        rdVal = busRdata;
    endtask
    // single read, answer an edge later
    task automatic rd(input logic [15:0] a);
        @(negedge clk);
        busAddr = a;
        busRe = 1'b1;
        @(negedge clk);
        busRe = 1'b0;
        @(negedge clk);
        rdVal = busRdata;
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        wr(16'haaaa, 8'haa);
        wr(16'h5554, 8'h55);
        wr(16'haaaa, 8'ha0);
        wr(a, d);
    endtask
    task automatic erase6(input logic [15:0] a, input logic [7:0] c);
        wr(16'haaaa, 8'haa);
        wr(16'h5554, 8'h55);
        wr(16'haaaa, 8'h80);
        wr(16'haaaa, 8'haa);
        wr(16'h5554, 8'h55);
        wr(a, c);
    endtask
endmodule

// ### tb/fcs_sequencer_tb.sv
`timescale 1ns/1ns
module fcs_sequencer_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic busWe, busRe, writeAllow, opBusy, eraseSuspended;
    logic [15:0] busAddr;
    logic [7:0] busWdata, busRdata, rv, st;
    int error_cnt = 0;
    int compares = 0;
    assign rv = i_fcs_cpu_model.rdVal;
    assign st = {6'h00, eraseSuspended, opBusy};
    always #2 clk = ~clk;
    fcs_sequencer #(.WAIT_CYC(20)) i_fcs_sequencer (.clk(clk),
        .rstn(rstn), .busWe(busWe), .busRe(busRe), .busAddr(busAddr),
        .busWdata(busWdata), .writeAllow(writeAllow),
        .busRdata(busRdata), .opBusy(opBusy),
        .eraseSuspended(eraseSuspended));
    fcs_cpu_model i_fcs_cpu_model (.clk(clk), .busRdata(busRdata),
        .busWe(busWe), .busRe(busRe), .busAddr(busAddr),
        .busWdata(busWdata), .writeAllow(writeAllow));
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    // bounded wait for the status word
    task automatic wt(input logic [7:0] v, input int n);
        for (int i = 0; i < n && st !== v; i++) @(negedge clk);
    endtask
    task automatic rst();
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_refuse();
        chk("st", 8'h00, st);
        i_fcs_cpu_model.allow(1'b0);
        i_fcs_cpu_model.prog(16'h0010, 8'h00);
        repeat (2) @(negedge clk);
        chk("st", 8'h00, st);
        i_fcs_cpu_model.allow(1'b1);
        i_fcs_cpu_model.erase6(16'h0010, 8'h00);
        i_fcs_cpu_model.wr(16'h0010, 8'h30);
        i_fcs_cpu_model.wr(16'h0000, 8'hb0);
        repeat (4) @(negedge clk);
        chk("st", 8'h00, st);
    endtask
    task automatic t_prog();
        i_fcs_cpu_model.prog(16'h0010, 8'h00);
        wt(8'h01, 4);
        chk("st", 8'h01, st);
        wt(8'h00, 40);
        i_fcs_cpu_model.rd(16'h0010);
        chk("data", 8'h00, rv);
    endtask
    task automatic t_fail();
        logic [7:0] v;
        i_fcs_cpu_model.prog(16'h0010, 8'h01);
        wt(8'h01, 4);
        i_fcs_cpu_model.rd(16'h0010);
        v = rv;
        chk("poll", 8'h80, v & 8'ha0);
        i_fcs_cpu_model.rd(16'h0020);
        chk("tog", ~v & 8'h40, rv & 8'h40);
        i_fcs_cpu_model.rd2(16'h0020);
        chk("tog", ~v & 8'h40, rv & 8'h40);
        i_fcs_cpu_model.wr(16'h0000, 8'hf0);
        repeat (200) @(negedge clk);
        chk("st", 8'h01, st);
        i_fcs_cpu_model.rd(16'h0010);
        chk("fail", 8'ha0, rv & 8'ha0);
        i_fcs_cpu_model.rd(16'h0010);
        chk("repoll", 8'h80, rv & 8'h80);
        i_fcs_cpu_model.wr(16'h0000, 8'hf0);
        wt(8'h00, 4);
        i_fcs_cpu_model.rd(16'h0010);
        chk("data", 8'h00, rv);
    endtask
    task automatic t_window();
        i_fcs_cpu_model.erase6(16'h1000, 8'h30);
        wt(8'h01, 4);
        i_fcs_cpu_model.rd(16'h1000);
        chk("win", 8'h00, rv & 8'h88);
        i_fcs_cpu_model.wr(16'h0000, 8'hb0);
        wt(8'h02, 4);
        chk("st", 8'h02, st);
        i_fcs_cpu_model.prog(16'h2000, 8'h00);
        i_fcs_cpu_model.wr(16'h0000, 8'hb0);
        repeat (4) @(negedge clk);
        chk("st", 8'h02, st);
        rst();
    endtask
    task automatic t_erase();
        i_fcs_cpu_model.erase6(16'h1000, 8'h30);
        repeat (10) @(negedge clk);
        i_fcs_cpu_model.wr(16'h2000, 8'h30);
        repeat (12) @(negedge clk);
        i_fcs_cpu_model.rd(16'h2000);
        chk("win", 8'h00, rv & 8'h88);
        repeat (20) @(negedge clk);
        i_fcs_cpu_model.rd(16'h1000);
        chk("win", 8'h08, rv & 8'h88);
        i_fcs_cpu_model.wr(16'h0000, 8'h30);
        chk("st", 8'h01, st);
        i_fcs_cpu_model.wr(16'h0000, 8'hb0);
        wt(8'h02, 3750);
        chk("st", 8'h02, st);
        i_fcs_cpu_model.rd(16'h1000);
        chk("sus", 8'hc8, rv & 8'hf8);
        i_fcs_cpu_model.rd(16'h2000);
        chk("sus", 8'hc8, rv & 8'hf8);
        i_fcs_cpu_model.rd(16'h0010);
        chk("data", 8'h00, rv);
        rst();
        i_fcs_cpu_model.erase6(16'haaaa, 8'h10);
        i_fcs_cpu_model.wr(16'h0000, 8'hb0);
        repeat (4) @(negedge clk);
        chk("st", 8'h01, st);
    endtask
    task automatic conclude();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        rst();
        t_refuse();
        t_prog();
        t_fail();
        t_window();
        t_erase();
        conclude();
    end
    // watchdog, well past the expected run length
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule
